// ==== bpu_top.sv ====
// breakpoint comparator unit: three comparators, axi4-lite register slave
// assumes cpu bus, secure and debug-busy inputs are on aclk; por_n is the power-on reset
`timescale 1ns/1ns
module bpu_top
  import bpu_pkg::*;
(
  // clock and resets
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         por_n,
  // axi4-lite slave
  input  wire logic [5:0]   s_axi_awaddr,
  input  wire logic         s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire logic [31:0]  s_axi_wdata,
  input  wire logic [3:0]   s_axi_wstrb,
  input  wire logic         s_axi_wvalid,
  output logic              s_axi_wready,
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire logic         s_axi_bready,
  input  wire logic [5:0]   s_axi_araddr,
  input  wire logic         s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire logic         s_axi_rready,
  // internal cpu side, no device pins [RULE6]
  input  wire bpu_cpu_bus_s cpu_bus,
  input  wire logic         secure_mode,
  input  wire logic         debug_cmd_busy,
  output bpu_break_s        brk_req,
  output logic              irq
);

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [2:0][7:0] hi;
    logic [2:0][7:0] lo;
    logic [2:0][7:0] ctl;
    logic [2:0]      flags;
    logic [2:0]      irq_mask;
    logic            aw_got;
    logic [3:0]      aw_idx;
    logic            aw_bad;
    logic            w_got;
    logic [7:0]      w_byte;
    logic            w_lane;
    logic            awready;
    logic            wready;
    logic            bvalid;
    logic [1:0]      bresp;
    logic            arready;
    logic            rvalid;
    logic [31:0]     rdata;
    logic [1:0]      rresp;
    bpu_break_s      brk;
    logic            irq;
  } bpu_state_s;

  bpu_state_s st_r;
  bpu_state_s st_nxt;

  logic [2:0] hit;
  logic [2:0] cmp_ok;
  logic       full_mode;
  logic       cmp_block;

  ////////////////////////////////////////////////////////////////////////////
  // comparators
  assign full_mode = st_r.ctl[0][BPU_CTL_FULL_MODE_ENABLE];
  assign cmp_block = secure_mode | debug_cmd_busy | ~cpu_bus.valid; // [RULE4] [RULE5]

  for (genvar i = 0; i < 3; i++) begin : g_cmp
    logic addr_eq;
    logic rw_eq;
    // full 16-bit address, no paging [RULE9] [RULE11]
    assign addr_eq = cpu_bus.addr == {st_r.hi[i], st_r.lo[i]};
    assign rw_eq   = ~st_r.ctl[i][BPU_CTL_RWEN] | (st_r.ctl[i][BPU_CTL_RW] == cpu_bus.read);
    assign cmp_ok[i] = rw_eq & st_r.ctl[i][BPU_CTL_EN] & ~cmp_block;
  end

  // in full mode b checks data only and a needs b's agreement [RULE2] [RULE12]
  assign hit[2] = full_mode ? (cmp_ok[0] & g_cmp[0].addr_eq & cpu_bus.data == st_r.lo[1])
                            : (cmp_ok[0] & g_cmp[0].addr_eq); // [RULE1]
  assign hit[1] = full_mode ? 1'b0 : (cmp_ok[1] & g_cmp[1].addr_eq);
  assign hit[0] = cmp_ok[2] & g_cmp[2].addr_eq;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [3:0] ar_idx;
    logic [2:0] fired_tag;
    logic [2:0] fired_force;
    logic [2:0] flag_clr;
    ar_idx      = s_axi_araddr[5:2];
    fired_tag   = '0;
    fired_force = '0;
    flag_clr    = '0;
    st_nxt      = st_r;

    // tag or force per comparator [RULE3] [RULE13]
    for (int i = 0; i < 3; i++) begin
      if (hit[2 - i] && st_r.ctl[i][BPU_CTL_TAG]) begin
        fired_tag[i] = 1'b1;
      end else if (hit[2 - i]) begin
        fired_force[i] = 1'b1;
      end
    end
    st_nxt.brk.tag       = |fired_tag;
    st_nxt.brk.force_req = |fired_force;

    // write address and data, taken in either order
    st_nxt.awready = 1'b0;
    st_nxt.wready  = 1'b0;
    if (!st_r.aw_got && s_axi_awvalid && !st_r.awready) begin
      st_nxt.awready = 1'b1;
      st_nxt.aw_got  = 1'b1;
      st_nxt.aw_idx  = s_axi_awaddr[5:2];
      st_nxt.aw_bad  = s_axi_awaddr[5:2] >= 4'(BPU_NUM_REGS);
    end
    if (!st_r.w_got && s_axi_wvalid && !st_r.wready) begin
      st_nxt.wready = 1'b1;
      st_nxt.w_got  = 1'b1;
      st_nxt.w_byte = s_axi_wdata[7:0];
      st_nxt.w_lane = s_axi_wstrb[0];
    end

    // reading the status byte clears it; a new hit wins over that clear
    st_nxt.arready = 1'b0;
    if (!st_r.rvalid && s_axi_arvalid && !st_r.arready) begin
      st_nxt.arready = 1'b1;
      st_nxt.rvalid  = 1'b1;
      st_nxt.rresp   = BPU_RESP_OKAY;
      st_nxt.rdata   = '0;
      if (ar_idx == BPU_IDX_A_HI) begin
        st_nxt.rdata[7:0] = st_r.hi[0];
      end else if (ar_idx == BPU_IDX_A_LO) begin
        st_nxt.rdata[7:0] = st_r.lo[0];
      end else if (ar_idx == BPU_IDX_B_HI) begin
        st_nxt.rdata[7:0] = st_r.hi[1];
      end else if (ar_idx == BPU_IDX_B_LO) begin
        st_nxt.rdata[7:0] = st_r.lo[1];
      end else if (ar_idx == BPU_IDX_C_HI) begin
        st_nxt.rdata[7:0] = st_r.hi[2];
      end else if (ar_idx == BPU_IDX_C_LO) begin
        st_nxt.rdata[7:0] = st_r.lo[2];
      end else if (ar_idx == BPU_IDX_A_CTL) begin
        st_nxt.rdata[7:0] = st_r.ctl[0];
      end else if (ar_idx == BPU_IDX_B_CTL) begin
        st_nxt.rdata[7:0] = st_r.ctl[1];
      end else if (ar_idx == BPU_IDX_C_CTL) begin
        st_nxt.rdata[7:0] = st_r.ctl[2];
      end else if (ar_idx == BPU_IDX_FLAGS) begin
        st_nxt.rdata[2:0] = st_r.flags;
        flag_clr          = 3'b111;
      end else if (ar_idx == BPU_IDX_IRQ_MSK) begin
        st_nxt.rdata[2:0] = st_r.irq_mask;
      end else begin
        st_nxt.rresp = BPU_RESP_SLVERR;
      end
    end else if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
    st_nxt.flags = (st_r.flags & ~flag_clr) | hit; // [RULE13]

    // commit once both halves are in; status byte ignores writes [RULE7] [RULE8]
    if (st_r.aw_got && st_r.w_got && !st_r.bvalid) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got  = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp  = st_r.aw_bad ? BPU_RESP_SLVERR : BPU_RESP_OKAY;
      if (st_r.w_lane) begin
        if (st_r.aw_idx == BPU_IDX_A_HI) begin
          st_nxt.hi[0] = st_r.w_byte;
        end else if (st_r.aw_idx == BPU_IDX_A_LO) begin
          st_nxt.lo[0] = st_r.w_byte;
        end else if (st_r.aw_idx == BPU_IDX_B_HI) begin
          st_nxt.hi[1] = st_r.w_byte;
        end else if (st_r.aw_idx == BPU_IDX_B_LO) begin
          st_nxt.lo[1] = st_r.w_byte;
        end else if (st_r.aw_idx == BPU_IDX_C_HI) begin
          st_nxt.hi[2] = st_r.w_byte;
        end else if (st_r.aw_idx == BPU_IDX_C_LO) begin
          st_nxt.lo[2] = st_r.w_byte;
        end else if (st_r.aw_idx == BPU_IDX_A_CTL) begin
          st_nxt.ctl[0] = st_r.w_byte & BPU_CTL_A_MASK;
        end else if (st_r.aw_idx == BPU_IDX_B_CTL) begin
          st_nxt.ctl[1] = st_r.w_byte & BPU_CTL_BC_MASK;
        end else if (st_r.aw_idx == BPU_IDX_C_CTL) begin
          st_nxt.ctl[2] = st_r.w_byte & BPU_CTL_BC_MASK;
        end else if (st_r.aw_idx == BPU_IDX_IRQ_MSK) begin
          st_nxt.irq_mask = st_r.w_byte[2:0];
        end
      end
    end else if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end

    st_nxt.irq = |(st_nxt.flags & st_nxt.irq_mask);
  end

  ////////////////////////////////////////////////////////////////////////////
  // comparator setup survives aresetn, only por_n reloads it [RULE10]
  always_ff @(posedge aclk) begin
    if (!por_n) begin
      st_r          <= '0;
      st_r.hi[0]    <= BPU_POR_A_HI;
      st_r.lo[0]    <= BPU_POR_A_LO;
      st_r.hi[1]    <= BPU_POR_ZERO;
      st_r.lo[1]    <= BPU_POR_ZERO;
      st_r.hi[2]    <= BPU_POR_ZERO;
      st_r.lo[2]    <= BPU_POR_ZERO;
    end else if (!aresetn) begin
      st_r          <= st_nxt;
      st_r.flags    <= '0;
      st_r.irq_mask <= '0;
      st_r.aw_got   <= 1'b0;
      st_r.w_got    <= 1'b0;
      st_r.awready  <= 1'b0;
      st_r.wready   <= 1'b0;
      st_r.bvalid   <= 1'b0;
      st_r.arready  <= 1'b0;
      st_r.rvalid   <= 1'b0;
      st_r.rdata    <= '0;
      st_r.brk      <= '0;
      st_r.irq      <= 1'b0;
      st_r.hi       <= st_r.hi;
      st_r.lo       <= st_r.lo;
      st_r.ctl      <= st_r.ctl;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign s_axi_awready = st_r.awready;
  assign s_axi_wready  = st_r.wready;
  assign s_axi_bvalid  = st_r.bvalid;
  assign s_axi_bresp   = st_r.bresp;
  assign s_axi_arready = st_r.arready;
  assign s_axi_rvalid  = st_r.rvalid;
  assign s_axi_rdata   = st_r.rdata;
  assign s_axi_rresp   = st_r.rresp;
  assign brk_req       = st_r.brk;
  assign irq           = st_r.irq;

endmodule

// ==== bpu_pkg.sv ====
// constants, field layouts and carriers of the breakpoint comparator unit
// assumes a single bus clock; cpu bus signals arrive on that same clock
//
// Summary of operation
// (RULE1) three comparators a, b and c each act as an independent hardware breakpoint.
// (RULE2) in full mode comparator a checks the address and comparator b the data, and both must agree.
// (RULE3) each comparator is set on its own to request a tag or a force breakpoint.
// (RULE4) no comparator fires while the device is in secure mode.
// (RULE5) no comparator fires while a background debug command is running.
// (RULE6) the unit has no pins; it sees only internal cpu buses and its registers.
// (RULE7) value bytes sit at offsets 0 to 5, control bytes at 6 to 8, status at 9.
// (RULE8) the status byte is read only; all value and control bytes read and write.
// (RULE9) each bit of a value byte sets whether the matching address bit must be 1 or 0.
// (RULE10) value and control bytes survive ordinary resets; only power-on reset loads them.
// (RULE11) the unit compares the full 16-bit address with no paging extension.
// (RULE12) with full mode set, comparator b low checks the data bus and b high is ignored.
// (RULE13) an enabled match sets its status flag and raises a tag or force request.
package bpu_pkg;

  // byte offsets: printed offsets are not all multiples of four, so address = 4 * index
  localparam logic [3:0] BPU_IDX_A_HI    = 4'h0;
  localparam logic [3:0] BPU_IDX_A_LO    = 4'h1;
  localparam logic [3:0] BPU_IDX_B_HI    = 4'h2;
  localparam logic [3:0] BPU_IDX_B_LO    = 4'h3;
  localparam logic [3:0] BPU_IDX_C_HI    = 4'h4;
  localparam logic [3:0] BPU_IDX_C_LO    = 4'h5;
  localparam logic [3:0] BPU_IDX_A_CTL   = 4'h6;
  localparam logic [3:0] BPU_IDX_B_CTL   = 4'h7;
  localparam logic [3:0] BPU_IDX_C_CTL   = 4'h8;
  localparam logic [3:0] BPU_IDX_FLAGS   = 4'h9;
  localparam logic [3:0] BPU_IDX_IRQ_MSK = 4'ha;
  localparam int         BPU_NUM_REGS    = 11;

  // control byte fields
  localparam int BPU_CTL_EN    = 7;
  localparam int BPU_CTL_RWEN  = 6;
  localparam int BPU_CTL_RW    = 5;
  localparam int BPU_CTL_TAG   = 4;
  localparam int BPU_CTL_FULL_MODE_ENABLE  = 1;
  localparam logic [7:0] BPU_CTL_A_MASK  = 8'hf3;
  localparam logic [7:0] BPU_CTL_BC_MASK = 8'hf0;

  // match_flags layout
  localparam int BPU_FLG_A = 2;
  localparam int BPU_FLG_B = 1;
  localparam int BPU_FLG_C = 0;

  // power-on values
  localparam logic [7:0] BPU_POR_A_HI = 8'hff;
  localparam logic [7:0] BPU_POR_A_LO = 8'hfe;
  localparam logic [7:0] BPU_POR_ZERO = 8'h00;

  localparam logic [1:0] BPU_RESP_OKAY   = 2'b00;
  localparam logic [1:0] BPU_RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  data;
    logic        valid;
    logic        read;
  } bpu_cpu_bus_s;

  typedef struct packed {
    logic tag;
    logic force_req;
  } bpu_break_s;

endpackage

// ==== bpu_cpu_model.sv ====
// cpu bus stand-in: shows a request while the bench asks for one
// assumes req is driven on aclk; an idle bus carries changing noise
`timescale 1ns/1ns
module bpu_cpu_model
  import bpu_pkg::*;
(
  // clock
  input  wire logic         aclk,
  // bench request, bus to dut
  input  wire bpu_cpu_bus_s req,
  output bpu_cpu_bus_s      cpu_bus
);
  logic [25:0] nz_r = 26'h2aaaaaa;
  // idle lines never keep the last value, so no stale match
  always_ff @(posedge aclk) nz_r <= ~nz_r;
  assign cpu_bus = req.valid ? req : {nz_r[25:2], 1'b0, nz_r[0]};
endmodule

// ==== bpu_top_chk.sv ====
// port assertions for the breakpoint unit
// assumes one clock domain; bound into every bpu_top
`timescale 1ns/1ns
module bpu_top_chk
  import bpu_pkg::*;
(
  // clock and reset
  input wire logic         aclk,
  input wire logic         aresetn,
  // register bus
  input wire logic         s_axi_bvalid,
  input wire logic         s_axi_bready,
  input wire logic [1:0]   s_axi_bresp,
  input wire logic         s_axi_arvalid,
  input wire logic         s_axi_arready,
  input wire logic [5:0]   s_axi_araddr,
  input wire logic         s_axi_rvalid,
  input wire logic         s_axi_rready,
  input wire logic [31:0]  s_axi_rdata,
  input wire logic [1:0]   s_axi_rresp,
  // cpu side
  input wire bpu_cpu_bus_s cpu_bus,
  input wire logic         secure_mode,
  input wire logic         debug_cmd_busy,
  input wire bpu_break_s   brk_req
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_rd_take;
    s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
  endsequence
  sequence s_rd_ans;
    s_axi_arready && s_axi_rvalid;
  endsequence
  AST_SECURE_OFF: assert property (secure_mode |=> brk_req == '0)
    else $error("break request in secure mode");
  AST_DEBUG_OFF: assert property (debug_cmd_busy |=> brk_req == '0)
    else $error("break request during debug command");
  AST_NO_CYCLE: assert property (!cpu_bus.valid |=> brk_req == '0)
    else $error("break request without cpu cycle");
  AST_RD_ANSWER: assert property (s_rd_take |=> s_rd_ans)
    else $error("read not answered next cycle");
  AST_RD_UNMAPPED: assert property (s_rd_take ##0 s_axi_araddr[5:2] > 4'ha |=> s_axi_rresp == BPU_RESP_SLVERR)
    else $error("unmapped read not refused");
  AST_RD_MAPPED: assert property (s_rd_take ##0 s_axi_araddr[5:2] < 4'hb |=> s_axi_rresp == BPU_RESP_OKAY)
    else $error("mapped read refused");
  AST_RD_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
  AST_RD_END: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response repeated");
  AST_WR_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
endmodule
bind bpu_top bpu_top_chk i_chk (.*);

// ==== bpu_top_tb.sv ====
// self-checking bench for the breakpoint unit
// assumes bpu_top, bpu_cpu_model and the checker are compiled first
`timescale 1ns/1ns
module bpu_top_tb
  import bpu_pkg::*;
;
  localparam logic [1:0] OK = BPU_RESP_OKAY;
  logic aclk = 1'b0, aresetn = 1'b0, por_n = 1'b0, secure_mode = 1'b0, debug_cmd_busy = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [5:0] s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, r, seed = 32'h70cd;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  bpu_cpu_bus_s cpu_req = '0, cpu_bus;
  bpu_break_s brk_req;
  logic [7:0] shadow [0:10];
  int miscompares = 0, n_checks = 0;
  initial forever #5 aclk = ~aclk;
  bpu_top i_dut (.*);
  bpu_cpu_model i_cpu (.aclk(aclk), .req(cpu_req), .cpu_bus(cpu_bus));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // unused control bits read back 0
  function automatic logic [7:0] rmask(input logic [3:0] i);
    return i == 4'ha ? 8'h07 : i == 4'h6 ? BPU_CTL_A_MASK : i > 4'h6 ? BPU_CTL_BC_MASK : 8'hff;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask
  task automatic close_out();
    if (miscompares == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic wr(input logic [3:0] i, input logic [7:0] d);
    logic ok = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= {i, 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (int n = 0; n < 40 && !ok; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) ok = 1'b1;
      s_axi_bready <= s_axi_bvalid && !s_axi_bready;
    end
    if (!ok) miscompares++;
    if (!ok) close_out();
    chk("bresp", OK, s_axi_bresp);
    if (i != 4'h9 && s_axi_wstrb[0]) shadow[i] = d & rmask(i);
  endtask
  task automatic rd(input logic [3:0] i, input logic [1:0] er);
    logic ok = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= {i, 2'b00};
    s_axi_arvalid <= 1'b1;
    for (int n = 0; n < 40 && !ok; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) ok = 1'b1;
      s_axi_rready <= s_axi_rvalid && !s_axi_rready;
    end
    if (!ok) miscompares++;
    if (!ok) close_out();
    chk("rresp", er, s_axi_rresp);
    if (er == OK) chk("rdata", {24'h0, shadow[i]}, s_axi_rdata);
    if (i == 4'h9) shadow[9] = 8'h00;
  endtask
  task automatic rd_all();
    for (int i = 0; i < 10; i++) rd(4'(i), OK);
  endtask
  task automatic cpu(input logic [15:0] a, input logic [7:0] d, input logic s, input logic b, input logic [1:0] eb);
    @(posedge aclk);
    cpu_req <= '{a, d, 1'b1, seed[0]};
    secure_mode <= s;
    debug_cmd_busy <= b;
    @(posedge aclk);
    cpu_req.valid <= 1'b0;
    secure_mode <= 1'b0;
    debug_cmd_busy <= 1'b0;
    @(negedge aclk);
    chk("brk_req", {30'h0, eb}, {30'h0, brk_req});
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    shadow = '{0: BPU_POR_A_HI, 1: BPU_POR_A_LO, default: 8'h00};
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    por_n <= 1'b1;
    rd_all();
    rd(4'hb, BPU_RESP_SLVERR);
    // a write without its byte lane must leave the register alone
    s_axi_wstrb <= 4'h0;
    wr(4'h0, 8'h5a);
    s_axi_wstrb <= 4'h1;
    rd(4'h0, OK);
    wr(4'h9, 8'h07);
    for (int i = 0; i < 9; i++) begin
      r = xs();
      wr(4'(i), r[7:0]);
    end
    rd_all();
    // ordinary reset keeps value and control bytes
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd_all();
    for (int i = 6; i < 9; i++) wr(4'(i), 8'h00);
    wr(BPU_IDX_IRQ_MSK, 8'h07);
    rd(BPU_IDX_IRQ_MSK, OK);
    for (int k = 0; k < 3; k++) begin
      r = xs();
      wr(4'(2 * k), r[15:8]);
      wr(4'(2 * k + 1), r[7:0]);
      wr(4'(6 + k), k == 1 ? 8'h80 : 8'h90);
      cpu(r[15:0] ^ (16'h1 << r[19:16]), r[23:16], 1'b0, 1'b0, 2'b00);
      cpu(r[15:0], r[23:16], 1'b1, 1'b0, 2'b00);
      cpu(r[15:0], r[23:16], 1'b0, 1'b1, 2'b00);
      cpu(r[15:0], r[23:16], 1'b0, 1'b0, k == 1 ? 2'b01 : 2'b10);
      chk("irq", 32'h1, {31'h0, irq});
      shadow[9] = 8'h04 >> k;
      rd(4'h9, OK);
      rd(4'h9, OK);
      chk("irq", 32'h0, {31'h0, irq});
      wr(4'(6 + k), 8'h00);
    end
    r = xs();
    wr(4'h0, r[15:8]);
    wr(4'h1, r[7:0]);
    wr(4'h3, r[23:16]);
    wr(4'h7, 8'h80);
    wr(4'h6, 8'h92);
    cpu(r[15:0], ~r[23:16], 1'b0, 1'b0, 2'b00);
    wr(BPU_IDX_IRQ_MSK, 8'h00);
    cpu(r[15:0], r[23:16], 1'b0, 1'b0, 2'b10);
    chk("irq", 32'h0, {31'h0, irq});
    shadow[9] = 8'h04;
    rd(4'h9, OK);
    // direction qualifier: c fires on read cycles only
    wr(4'h6, 8'h00);
    wr(4'h7, 8'h00);
    r = xs();
    wr(4'h4, r[15:8]);
    wr(4'h5, r[7:0]);
    wr(4'h8, 8'hf0);
    cpu(r[15:0], r[23:16], 1'b0, 1'b0, {seed[0], 1'b0});
    r[31:24] = 8'(xs());
    cpu(r[15:0], r[23:16], 1'b0, 1'b0, {seed[0], 1'b0});
    close_out();
  end
endmodule
